// ==== dsq_defs.vh ====
// constants for the debug state sequencer top and its next-state block
`ifndef DSQ_DEFS_VH
`define DSQ_DEFS_VH

// =====================================================
// register map (ADDR byte addresses, apb word aligned; IDX is the word index)
`define DSQ_IDX_SEL_CODE   8'h27
`define DSQ_ADDR_SEL_CODE  12'h09c
`define DSQ_ADDR_CTRL      12'h0a0
`define DSQ_ADDR_STATUS    12'h0a4

// =====================================================
// fields
`define DSQ_CODE_W         4
`define DSQ_BANK_LSB       0
`define DSQ_BANK_MSB       1
`define DSQ_ARM_BIT        2
`define DSQ_BANK_S1        2'b00
`define DSQ_BANK_S2        2'b01

// =====================================================
// reset values
`define DSQ_RST_CODE       4'h0
`define DSQ_RST_BANK       2'b00

// =====================================================
// sequencer states
`define DSQ_ST_W           3
`define DSQ_ST_IDLE        3'h0
`define DSQ_ST_1           3'h1
`define DSQ_ST_2           3'h2
`define DSQ_ST_3           3'h3
`define DSQ_ST_FINAL       3'h4

`endif

// ==== dsq_next_sel.v ====
// next-state decode for state1 and state2 select codes
`timescale 1ns/1ps
`include "dsq_defs.vh"

module dsq_next_sel (
  input wire [2:0] cur_state,
  input wire [3:0] code_s1,
  input wire [3:0] code_s2,
  input wire [2:0] match,
  output reg [2:0] next_state,
  output reg hit
);

  // =====================================================
  // per-channel targets, idle code means no effect
  reg [2:0] t0;
  reg [2:0] t1;
  reg [2:0] t2;

  // table decode
  always @* begin
    t0 = `DSQ_ST_IDLE;
    t1 = `DSQ_ST_IDLE;
    t2 = `DSQ_ST_IDLE;
    if (cur_state == `DSQ_ST_1) begin
      case (code_s1)
        4'h0: begin
          t0 = `DSQ_ST_FINAL;
          t1 = `DSQ_ST_FINAL;
          t2 = `DSQ_ST_FINAL;
        end
        4'h1: t1 = `DSQ_ST_3;
        4'h2: t2 = `DSQ_ST_2;
        4'h3: t1 = `DSQ_ST_2;
        4'h4: begin
          t0 = `DSQ_ST_2;
          t1 = `DSQ_ST_3;
        end
        4'h5: begin
          t1 = `DSQ_ST_3;
          t0 = `DSQ_ST_FINAL;
        end
        4'h6: begin
          t0 = `DSQ_ST_2;
          t2 = `DSQ_ST_3;
        end
        4'h7: begin
          t0 = `DSQ_ST_2;
          t1 = `DSQ_ST_2;
        end
        4'h9: t0 = `DSQ_ST_3;
        4'hd: begin
          t0 = `DSQ_ST_FINAL;
          t2 = `DSQ_ST_FINAL;
          t1 = `DSQ_ST_2;
        end
        // reserved codes move nothing
        default: t0 = `DSQ_ST_IDLE;
      endcase
    end else if (cur_state == `DSQ_ST_2) begin
      case (code_s2)
        4'h0: begin
          t0 = `DSQ_ST_1;
          t2 = `DSQ_ST_3;
        end
        4'h1: t1 = `DSQ_ST_3;
        4'h2: t2 = `DSQ_ST_3;
        4'h3: begin
          t1 = `DSQ_ST_3;
          t0 = `DSQ_ST_FINAL;
        end
        4'h4: begin
          t1 = `DSQ_ST_1;
          t2 = `DSQ_ST_3;
        end
        4'h5: t2 = `DSQ_ST_FINAL;
        4'h6: begin
          t2 = `DSQ_ST_1;
          t0 = `DSQ_ST_FINAL;
        end
        4'h7: begin
          t0 = `DSQ_ST_FINAL;
          t1 = `DSQ_ST_FINAL;
        end
        4'hc: begin
          t0 = `DSQ_ST_FINAL;
          t1 = `DSQ_ST_FINAL;
          t2 = `DSQ_ST_3;
        end
        4'hf: begin
          t0 = `DSQ_ST_FINAL;
          t1 = `DSQ_ST_FINAL;
          t2 = `DSQ_ST_1;
        end
        default: t0 = `DSQ_ST_IDLE;
      endcase
    end
  end

  // =====================================================
  // priority resolve
  always @* begin
    next_state = cur_state;
    hit = 1'b0;
    if (match[0] && t0 == `DSQ_ST_FINAL) begin
      next_state = t0;
      hit = 1'b1;
    end else if (match[1] && t1 == `DSQ_ST_FINAL) begin
      next_state = t1;
      hit = 1'b1;
    end else if (match[2] && t2 == `DSQ_ST_FINAL) begin
      next_state = t2;
      hit = 1'b1;
    end else if (match[0] && t0 != `DSQ_ST_IDLE) begin
      next_state = t0;
      hit = 1'b1;
    end else if (match[1] && t1 != `DSQ_ST_IDLE) begin
      next_state = t1;
      hit = 1'b1;
    end else if (match[2] && t2 != `DSQ_ST_IDLE) begin
      next_state = t2;
      hit = 1'b1;
    end
  end

endmodule // dsq_next_sel

// ==== dsq_seq_top.v ====
// debug state sequencer with banked next-state select registers on apb
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "dsq_defs.vh"

module dsq_seq_top (
  input wire core_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] match_in,
  output reg [2:0] seq_state,
  output reg seq_final,
  output reg armed
);

  // =====================================================
  // reset release through two flops
  reg rst_s1_q;
  reg rst_s2_q;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_n_int;
  assign rst_n_int = rst_s2_q;

  // =====================================================
  // register state
  reg [3:0] code_s1_q;
  reg [3:0] code_s2_q;
  reg [1:0] bank_q;
  reg arm_q;
  reg [2:0] state_q;

  // apb strobes; one-cycle access, pready high in access phase
  wire acc;
  wire wr;
  wire rd;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  wire hit_code;
  wire hit_ctrl;
  wire hit_stat;
  assign hit_code = (paddr == `DSQ_ADDR_SEL_CODE);
  assign hit_ctrl = (paddr == `DSQ_ADDR_CTRL);
  assign hit_stat = (paddr == `DSQ_ADDR_STATUS);

  // =====================================================
  // writable registers
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      code_s1_q <= `DSQ_RST_CODE;
      code_s2_q <= `DSQ_RST_CODE;
      bank_q <= `DSQ_RST_BANK;
      arm_q <= 1'b0;
    end else if (wr) begin
      if (hit_code && bank_q == `DSQ_BANK_S1 && !arm_q) begin
        code_s1_q <= pwdata[`DSQ_CODE_W-1:0];
      end
      if (hit_code && bank_q == `DSQ_BANK_S2 && !arm_q) begin
        code_s2_q <= pwdata[`DSQ_CODE_W-1:0];
      end
      // bank select and arm stay writable at all times
      if (hit_ctrl) begin
        bank_q <= pwdata[`DSQ_BANK_MSB:`DSQ_BANK_LSB];
        arm_q <= pwdata[`DSQ_ARM_BIT];
      end
    end
  end

  // =====================================================
  // read mux, combinational then registered into prdata
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_code) begin
      if (bank_q == `DSQ_BANK_S1) begin
        rdata_d = {28'h000_0000, code_s1_q};
      end else if (bank_q == `DSQ_BANK_S2) begin
        rdata_d = {28'h000_0000, code_s2_q};
      end
    end else if (hit_ctrl) begin
      rdata_d = {29'h0000_0000, arm_q, bank_q};
    end else if (hit_stat) begin
      rdata_d = {29'h0000_0000, state_q};
    end
  end

  // apb answer: ready and data registered in setup cycle
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_code | hit_ctrl | hit_stat);
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // =====================================================
  // next-state decode
  wire [2:0] nxt;
  wire nxt_hit;

  dsq_next_sel u_sel (
    .cur_state(state_q),
    .code_s1(code_s1_q),
    .code_s2(code_s2_q),
    .match(match_in),
    .next_state(nxt),
    .hit(nxt_hit)
  );

  // =====================================================
  // sequencer: arming starts in state1, disarm returns to idle
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_q <= `DSQ_ST_IDLE;
    end else if (!arm_q) begin
      state_q <= `DSQ_ST_IDLE;
    end else if (state_q == `DSQ_ST_IDLE) begin
      state_q <= `DSQ_ST_1;
    end else if (nxt_hit) begin
      state_q <= nxt;
    end
  end

  // outputs straight from flops
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      seq_state <= `DSQ_ST_IDLE;
      seq_final <= 1'b0;
      armed <= 1'b0;
    end else begin
      seq_state <= state_q;
      seq_final <= (state_q == `DSQ_ST_FINAL);
      armed <= arm_q;
    end
  end

endmodule // dsq_seq_top

// ==== dsq_seq_top_properties.sv ====
// port checker for the sequencer top
`timescale 1ns/1ps
`include "dsq_defs.vh"

module dsq_seq_props (
  input wire core_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] match_in,
  input wire [2:0] seq_state,
  input wire seq_final,
  input wire armed
);
  // ====
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // bus answers
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_upper_zero: assert property (pready |-> prdata[31:4] == 28'h0)
    else $error("upper read bits set");
  // state outputs; armed held two cycles covers either arm copy latency
  chk_final_flag: assert property (seq_final == (seq_state == `DSQ_ST_FINAL))
    else $error("final flag disagrees with state");
  chk_s1_quiet: assert property (
    armed && $past(armed) && seq_state == `DSQ_ST_1 && $past(match_in) == 3'h0 |=> seq_state == `DSQ_ST_1)
    else $error("state1 left without match");
  chk_s2_quiet: assert property (
    armed && $past(armed) && seq_state == `DSQ_ST_2 && $past(match_in) == 3'h0 |=> $stable(seq_state))
    else $error("state2 left without match");
  chk_arm_start: assert property ($rose(armed) |-> ##[1:2] seq_state == `DSQ_ST_1)
    else $error("arming did not enter state1");
  // main scenarios
  cover property (seq_state == `DSQ_ST_3);
  cover property (seq_final);
  cover property (pslverr);
endmodule // dsq_seq_props

bind dsq_seq_top dsq_seq_props u_props (.core_clk, .rst_b, .psel, .penable, .prdata, .pready, .pslverr,
  .match_in, .seq_state, .seq_final, .armed);

// ==== tb_dsq_seq_top.sv ====
// self-checking bench for the sequencer top
`timescale 1ns/1ps
`include "dsq_defs.vh"

module tb_dsq_seq_top;
  reg core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rdat;
  reg [2:0] match_in = 0;
  wire [31:0] prdata;
  wire pready, pslverr, seq_final, armed;
  wire [2:0] seq_state;
  integer errors = 0, samples_checked = 0, seed = 32'h1d70, st, c;
  // per code targets {ch2,ch1,ch0}: 0 none, 4 final
  reg [11:0] t1 [0:15], t2 [0:15];

  // ====
  // clock and dut
  always #2.5 core_clk = ~core_clk;
  dsq_seq_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_in(match_in), .seq_state(seq_state), .seq_final(seq_final), .armed(armed));

  // ====
  // model: lowest channel first, final overrides
  function integer nx(input integer s, input [3:0] a, input [3:0] b, input [2:0] m);
    reg [11:0] t;
    integer j;
    begin
      t = (s == 1) ? t1[a] : t2[b];
      nx = s;
      if (s == 1 || s == 2) begin
        for (j = 2; j >= 0; j = j - 1)
          if (m[j] && t[4*j+:4] != 0) nx = t[4*j+:4];
        for (j = 0; j < 3; j = j + 1)
          if (m[j] && t[4*j+:4] == 4) nx = 4;
      end
    end
  endfunction

  // ====
  // checking and closing
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // ====
  // apb master, idle cycle between transfers avoids double drives
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n = n + 1)
        @(posedge core_clk);
      if (n == 20) begin
        errors = errors + 1;
        end_sim;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
    end
  endtask

  // ====
  // one armed run: random one-cycle matches, state2 runs enter via code 0010
  task trial(input [3:0] a, input [3:0] b, input s2);
    integer j, r;
    reg [2:0] m;
    begin
      wr(`DSQ_ADDR_CTRL, 32'h0);
      wr(`DSQ_ADDR_SEL_CODE, a);
      wr(`DSQ_ADDR_CTRL, 32'h1);
      wr(`DSQ_ADDR_SEL_CODE, b);
      wr(`DSQ_ADDR_CTRL, 32'h4);
      st = 1;
      for (j = 0; j < 4; j = j + 1) begin
        r = $random(seed);
        // every pulse stands for an enabled comparator
        m = (j == 0 && s2) ? 3'h4 : r[2:0];
        @(posedge core_clk);
        match_in <= m;
        @(posedge core_clk);
        match_in <= 3'h0;
        st = nx(st, a, b, m);
        repeat (3) @(posedge core_clk);
        chk(seq_state, st);
        chk(seq_final, st == 4);
      end
      chk(armed, 1'b1);
      rd(`DSQ_ADDR_STATUS, st);
    end
  endtask

  // ====
  // main sequence
  initial begin
    t1 = '{12'h444, 12'h030, 12'h200, 12'h020, 12'h032, 12'h034, 12'h302, 12'h022,
      12'h000, 12'h003, 12'h000, 12'h000, 12'h000, 12'h424, 12'h000, 12'h000};
    t2 = '{12'h301, 12'h030, 12'h300, 12'h034, 12'h310, 12'h400, 12'h104, 12'h044,
      12'h000, 12'h000, 12'h000, 12'h000, 12'h344, 12'h000, 12'h000, 12'h144};
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    // internal reset lags two edges; first setup goes on the third
    repeat (2) @(posedge core_clk);
    rd(`DSQ_ADDR_SEL_CODE, 32'h0);
    chk(rerr, 1'b0);
    rd(`DSQ_ADDR_STATUS, 32'h0);
    rd(12'h0a8, 32'h0);
    chk(rerr, 1);
    wr(`DSQ_ADDR_SEL_CODE, 32'h5);
    wr(`DSQ_ADDR_CTRL, 32'h1);
    wr(`DSQ_ADDR_SEL_CODE, 32'hc);
    rd(`DSQ_ADDR_SEL_CODE, 32'hc);
    wr(`DSQ_ADDR_CTRL, 32'h2);
    wr(`DSQ_ADDR_SEL_CODE, 32'h9);
    rd(`DSQ_ADDR_SEL_CODE, 32'h0);
    wr(`DSQ_ADDR_CTRL, 32'h5);
    wr(`DSQ_ADDR_SEL_CODE, 32'h3);
    rd(`DSQ_ADDR_SEL_CODE, 32'hc);
    wr(`DSQ_ADDR_CTRL, 32'h4);
    wr(`DSQ_ADDR_SEL_CODE, 32'h7);
    rd(`DSQ_ADDR_SEL_CODE, 32'h5);
    for (c = 0; c < 16; c = c + 1) begin
      trial(c, 4'h0, 1'b0);
      trial(4'h2, c, 1'b1);
    end
    end_sim;
  end
endmodule // tb_dsq_seq_top
